// file: verilog/boot_width_pkg.sv
// Shared constants and carrier types for the boot bus width strap block.
// Assumes a single 10 MHz system clock and synchronous active-low reset.
package boot_width_pkg;

	// ------------------------------------------------------------
	// Widths and encodings
	// ------------------------------------------------------------
	localparam int unsigned NUM_SELECTS = 8;
	localparam logic WIDTH_8 = 1'h0;
	localparam logic WIDTH_16 = 1'h1;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic RST_LATCHED_WIDTH = 1'h1;
	localparam logic RST_PORT_SELECT = 1'h0;
	localparam logic RST_CLOCK_HALVING = 1'h1;
	localparam logic RST_PORT_DATA = 1'h0;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 10000000;
	localparam int unsigned RESET_MIN_MS = 250;
	localparam int unsigned RESET_MIN_CYCLES = RESET_MIN_MS * (CLK_FREQ_HZ / 1000);
	localparam int unsigned SYNC_STAGES = 2;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_RESET = 3'h1,
		ST_CAPTURE = 3'h2,
		ST_RUN = 3'h4
	} phase_t;

	typedef struct packed
	{
		logic port_select;
		logic clock_halving;
		logic port_data;
	} sw_cfg_t;

	typedef struct packed
	{
		logic port_select;
		logic clock_halving;
		logic latched_width;
	} status_t;

endpackage

// file: verilog/strap_sync.sv
// Two-stage synchroniser for a level arriving from a pin.
// Assumes the level is slow compared with the system clock.
`timescale 1ns/1ps
module strap_sync
(
	input wire logic clk_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_q;
	logic sync_q;

	// ------------------------------------------------------------
	// Synchroniser stages
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		meta_q <= d_i;
		sync_q <= meta_q;
	end

	assign q_o = sync_q;
endmodule

// file: verilog/boot_bus_width_strap.sv
// Reset-time bus width configuration from the boot width strap pin.
// Assumes clk_i runs through reset and software drives the config ports.
`timescale 1ns/1ps
// Contract
// - Boot and second group A selects take width only from strap.
// - Other selects are software programmable to 8 or 16 bits.
// - Strap high or open during reset means 16-bit boot group.
// - Strap driven low throughout reset gives 8-bit boot group.
// - Strap level captured when reset deasserts.
// - Captured level readable as the latched width flag.
// - Shared pin defaults to transfer acknowledge; software may pick port bit.
// - Clock halving bit set after reset, halving the system clock.
module boot_bus_width_strap
#(
	parameter int unsigned NUM_SEL = boot_width_pkg::NUM_SELECTS
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic boot_width_strap_i,
	input wire logic [NUM_SEL-1:0] sel_width_wr_i,
	input wire logic [NUM_SEL-1:0] sel_width_val_i,
	input wire logic cfg_wr_i,
	input wire boot_width_pkg::sw_cfg_t cfg_i,
	output logic boot_chip_select_width_o,
	output logic second_group_a_select_width_o,
	output logic [NUM_SEL-1:0] sel_width_o,
	output logic latched_width_flag_o,
	output logic transfer_acknowledge_en_o,
	output logic port_g_bit_zero_o,
	output logic port_g_bit_zero_oe_n_o,
	output logic transfer_acknowledge_o,
	output logic clock_halving_bit_o,
	output logic clk_half_en_o,
	output boot_width_pkg::status_t status_o
);
	logic strap_sync;
	logic ack_sync;
	logic strap_sample_q;
	logic latched_width_q;
	logic [NUM_SEL-1:0] sel_width_q;
	logic port_select_q;
	logic clock_halving_q;
	logic port_data_q;
	logic half_toggle_q;
	logic ack_q;
	boot_width_pkg::phase_t phase_q;

	// ------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------
	strap_sync u_strap_sync
	(
		.clk_i(clk_i),
		.d_i(boot_width_strap_i),
		.q_o(strap_sync)
	);

	// Shared pin carries the strap level and the acknowledge input alike
	assign ack_sync = strap_sync;

	// ------------------------------------------------------------
	// Reset phase tracking
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			phase_q <= boot_width_pkg::ST_RESET;
		end
		else
		begin
			case (phase_q)
				// Two steps out of reset: capture, then run
				boot_width_pkg::ST_RESET: phase_q <= boot_width_pkg::ST_CAPTURE;
				boot_width_pkg::ST_CAPTURE: phase_q <= boot_width_pkg::ST_RUN;
				boot_width_pkg::ST_RUN: phase_q <= boot_width_pkg::ST_RUN;
				default: phase_q <= boot_width_pkg::ST_RESET;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Strap tracking and capture
	// ------------------------------------------------------------
	// Follow the strap while reset is held; last value is the one at release
	// Strap must settle a few cycles before release to clear the synchroniser
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			strap_sample_q <= strap_sync;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			latched_width_q <= boot_width_pkg::RST_LATCHED_WIDTH;
		end
		else if (phase_q == boot_width_pkg::ST_RESET)
		begin
			// Taken once, in the first cycle after release
			// High or open means 16-bit, low means 8-bit
			latched_width_q <= strap_sample_q;
		end
		// Otherwise hold until next reset
	end

	// ------------------------------------------------------------
	// Programmable select widths
	// ------------------------------------------------------------
	// Group A selects are not in this set; their width is strap-only
	// Strobes during reset fall into the reset branch and are lost
	for (genvar i = 0; i < NUM_SEL; i++)
	begin : g_sel
		always_ff @(posedge clk_i)
		begin
			if (!rstn_i)
			begin
				sel_width_q[i] <= boot_width_pkg::WIDTH_8;
			end
			else if (sel_width_wr_i[i])
			begin
				sel_width_q[i] <= sel_width_val_i[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Shared pin function and clock halving
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			port_select_q <= boot_width_pkg::RST_PORT_SELECT;
			clock_halving_q <= boot_width_pkg::RST_CLOCK_HALVING;
			port_data_q <= boot_width_pkg::RST_PORT_DATA;
		end
		else if (cfg_wr_i)
		begin
			port_select_q <= cfg_i.port_select;
			clock_halving_q <= cfg_i.clock_halving;
			// All three fields load together on one strobe
			port_data_q <= cfg_i.port_data;
		end
	end

	// Acknowledge seen only while the pin serves that function
	// Pin is active low; a low level acknowledges the cycle
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			ack_q <= 1'h0;
		end
		else
		begin
			ack_q <= !port_select_q && !ack_sync;
		end
	end

	// Clock enable pattern: every other cycle while halving
	// Halved clock is modelled as an enable, so no second clock exists
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			half_toggle_q <= 1'h0;
		end
		else if (clock_halving_q)
		begin
			half_toggle_q <= !half_toggle_q;
		end
		else
		begin
			half_toggle_q <= 1'h1;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			boot_chip_select_width_o <= boot_width_pkg::RST_LATCHED_WIDTH;
			second_group_a_select_width_o <= boot_width_pkg::RST_LATCHED_WIDTH;
			sel_width_o <= '0;
			latched_width_flag_o <= boot_width_pkg::RST_LATCHED_WIDTH;
			transfer_acknowledge_en_o <= 1'h1;
			port_g_bit_zero_o <= boot_width_pkg::RST_PORT_DATA;
			port_g_bit_zero_oe_n_o <= 1'h1;
			transfer_acknowledge_o <= 1'h0;
			clock_halving_bit_o <= boot_width_pkg::RST_CLOCK_HALVING;
			clk_half_en_o <= 1'h0;
			status_o <= '0;
		end
		else
		begin
			// Every output is a flop, so pins see no glitches
			boot_chip_select_width_o <= latched_width_q;
			second_group_a_select_width_o <= latched_width_q;
			sel_width_o <= sel_width_q;
			latched_width_flag_o <= latched_width_q;
			transfer_acknowledge_en_o <= !port_select_q;
			port_g_bit_zero_o <= port_data_q;
			port_g_bit_zero_oe_n_o <= !port_select_q;
			transfer_acknowledge_o <= ack_q;
			clock_halving_bit_o <= clock_halving_q;
			clk_half_en_o <= half_toggle_q;
			status_o.port_select <= port_select_q;
			status_o.clock_halving <= clock_halving_q;
			status_o.latched_width <= latched_width_q;
		end
	end
endmodule

// file: tb/boot_width_checker.sv
// Port assertions for boot_bus_width_strap.
// Bound into every instance of the design top.
`timescale 1ns/1ps
module boot_width_checker
#(
	parameter int unsigned NUM_SEL = 8
)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic boot_width_strap_i,
	input wire logic [NUM_SEL-1:0] sel_width_wr_i,
	input wire logic [NUM_SEL-1:0] sel_width_val_i,
	input wire logic cfg_wr_i,
	input wire boot_width_pkg::sw_cfg_t cfg_i,
	input wire logic boot_chip_select_width_o,
	input wire logic second_group_a_select_width_o,
	input wire logic [NUM_SEL-1:0] sel_width_o,
	input wire logic latched_width_flag_o,
	input wire logic transfer_acknowledge_en_o,
	input wire logic port_g_bit_zero_o,
	input wire logic clock_halving_bit_o,
	input wire logic clk_half_en_o,
	input wire boot_width_pkg::status_t status_o
);
	logic strap_q;
	// Strap level seen during reset
	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			strap_q <= boot_width_strap_i;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	property p_grp;
		latched_width_flag_o == boot_chip_select_width_o &&
		latched_width_flag_o == second_group_a_select_width_o;
	endproperty
	property p_cap;
		rstn_i && $past(rstn_i, 3) |-> latched_width_flag_o == strap_q;
	endproperty
	property p_hold;
		rstn_i && $past(rstn_i, 3) |-> $stable(latched_width_flag_o);
	endproperty
	property p_sel;
		|sel_width_wr_i |-> ##2
		((sel_width_o ^ $past(sel_width_val_i, 2)) & $past(sel_width_wr_i, 2)) == '0;
	endproperty
	property p_cfg;
		cfg_wr_i |-> ##2 transfer_acknowledge_en_o == !$past(cfg_i.port_select, 2) &&
		clock_halving_bit_o == $past(cfg_i.clock_halving, 2) &&
		port_g_bit_zero_o == $past(cfg_i.port_data, 2) &&
		status_o.port_select == $past(cfg_i.port_select, 2);
	endproperty
	property p_def;
		$rose(rstn_i) |-> (transfer_acknowledge_en_o && clock_halving_bit_o) [*2];
	endproperty
	property p_tog;
		$past(rstn_i, 3) && clock_halving_bit_o && $past(clock_halving_bit_o) &&
		$past(clock_halving_bit_o, 2) |-> clk_half_en_o != $past(clk_half_en_o);
	endproperty
	property p_full;
		!clock_halving_bit_o && !$past(clock_halving_bit_o) &&
		!$past(clock_halving_bit_o, 2) |-> clk_half_en_o;
	endproperty
	a_grp: assert property (p_grp) else $error("group A width differs from flag");
	a_cap: assert property (p_cap) else $error("flag differs from reset strap");
	a_hold: assert property (p_hold) else $error("flag moved after reset");
	a_sel: assert property (p_sel) else $error("select width not written");
	a_cfg: assert property (p_cfg) else $error("config write not applied");
	a_def: assert property (p_def) else $error("defaults wrong after reset");
	a_tog: assert property (p_tog) else $error("clock enable not halving");
	a_full: assert property (p_full) else $error("clock enable not full rate");
	c_narrow: cover property ($rose(rstn_i) ##2 !latched_width_flag_o);
	c_cfg: cover property (cfg_wr_i && cfg_i.port_select);
	c_sel: cover property (|sel_width_wr_i);
endmodule
bind boot_bus_width_strap boot_width_checker #(.NUM_SEL(NUM_SEL)) u_chk (.*);

// file: tb/boot_rom_model.sv
// Far side model: boot ROM strap and acknowledge source.
// The pin has a pull-up, so released means high.
`timescale 1ns/1ps
module boot_rom_model
(
	input wire logic rstn_i,
	input wire logic narrow_i,
	input wire logic ack_req_i,
	output logic pin_o
);
	// Low through reset for an 8-bit ROM, held low after it
	assign pin_o = !rstn_i ? !narrow_i : !(narrow_i || ack_req_i);
endmodule

// file: tb/boot_bus_width_strap_test.sv
// Self-checking bench for boot_bus_width_strap.
// Uses boot_rom_model on the strap pin and the bound checker.
`timescale 1ns/1ps
module boot_bus_width_strap_test;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic narrow = 1'b0;
	logic ack_req = 1'b0;
	logic pin;
	logic [7:0] wr = 8'h00;
	logic [7:0] val = 8'h00;
	logic cfg_wr = 1'b0;
	boot_width_pkg::sw_cfg_t cfg = 3'h0;
	logic bw, sw, flag, ack_en, half, ack, look;
	logic [7:0] sel;
	logic [7:0] msel = 8'h00;
	boot_width_pkg::status_t st;
	logic pg, pg_oe_n;
	logic mpd = 1'b0;
	logic [18:0] q[$];
	logic [18:0] m;
	int bad_count = 0;
	int total_checks = 0;
	int cycles = 0;
	always #50 clk_i = !clk_i;
	boot_rom_model u_rom (.rstn_i(rstn_i), .narrow_i(narrow), .ack_req_i(ack_req), .pin_o(pin));
	boot_bus_width_strap dut (.clk_i(clk_i), .rstn_i(rstn_i), .boot_width_strap_i(pin),
		.sel_width_wr_i(wr), .sel_width_val_i(val), .cfg_wr_i(cfg_wr), .cfg_i(cfg),
		.boot_chip_select_width_o(bw), .second_group_a_select_width_o(sw), .sel_width_o(sel),
		.latched_width_flag_o(flag), .transfer_acknowledge_en_o(ack_en), .port_g_bit_zero_o(pg),
		.port_g_bit_zero_oe_n_o(pg_oe_n), .transfer_acknowledge_o(ack), .clock_halving_bit_o(half),
		.clk_half_en_o(), .status_o(st));
	task automatic final_report();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#10;
	endtask
	function automatic logic [18:0] ex(input logic f, input logic ae, input logic h,
		input logic ak);
		return {f, f, f, msel, ae, h, !ae, h, f, ak, mpd, ae};
	endfunction
	task automatic note(input logic [18:0] e);
		q.push_back(e);
		look = 1'b1;
		step(1);
		look = 1'b0;
	endtask
	task automatic rst(input logic n);
		rstn_i = 1'b0;
		narrow = n;
		ack_req = 1'b0;
		msel = 8'h00;
		mpd = 1'b0;
		step(10);
		rstn_i = 1'b1;
		step(4);
	endtask
	// Result watcher
	always @(negedge clk_i)
	begin
		if (look === 1'b1)
		begin
			total_checks++;
			m = q.pop_front();
			if ({flag, bw, sw, sel, ack_en, half, st, ack, pg, pg_oe_n} !== m)
			begin
				bad_count++;
				$display("ERROR %0t: got %h want %h", $time, {flag, bw, sw, sel, ack_en,
					half, st, ack, pg, pg_oe_n}, m);
			end
		end
	end
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			bad_count++;
			final_report();
		end
	end
	initial
	begin
		look = 1'b0;
		void'($urandom(94));
		rst(1'b0);
		note(ex(1'b1, 1'b1, 1'b1, 1'b0));
		ack_req = 1'b1;
		step(6);
		note(ex(1'b1, 1'b1, 1'b1, 1'b1));
		ack_req = 1'b0;
		repeat (6)
		begin
			wr = 8'($urandom);
			val = 8'($urandom);
			msel = (msel & ~wr) | (val & wr);
			step(1);
		end
		wr = 8'h00;
		step(2);
		note(ex(1'b1, 1'b1, 1'b1, 1'b0));
		cfg = 3'h6;
		cfg_wr = 1'b1;
		step(1);
		// Port function before full rate
		cfg = 3'h5;
		mpd = 1'b1;
		step(1);
		cfg_wr = 1'b0;
		step(2);
		note(ex(1'b1, 1'b0, 1'b0, 1'b0));
		rst(1'b1);
		step(4);
		note(ex(1'b0, 1'b1, 1'b1, 1'b1));
		final_report();
	end
endmodule
